// ### design/codec_path_pkg.sv
package codec_path_pkg;

   // control word address space
   localparam logic [6:0] REG_ANALOG   = 7'h04;
   localparam logic [6:0] REG_DIGITAL  = 7'h05;

   // analog_path_control fields
   localparam int unsigned SRC_SEL_BIT  = 2;
   localparam int unsigned BYPASS_BIT   = 3;
   localparam int unsigned DAC_SEL_BIT  = 4;
   localparam int unsigned SIDETONE_BIT = 5;
   localparam logic [8:0]  ANALOG_RST   = 9'h00A;

   // digital_path_control fields
   localparam int unsigned HPD_BIT      = 0;
   localparam int unsigned DEEMPH_LSB   = 1;
   localparam int unsigned MUTE_BIT     = 3;
   localparam int unsigned HOLD_BIT     = 4;
   localparam logic [8:0]  DIGITAL_RST  = 9'h008;

   // de-emphasis select codes
   localparam logic [1:0] DEEMPH_OFF = 2'h0;
   localparam logic [1:0] DEEMPH_32K = 2'h1;
   localparam logic [1:0] DEEMPH_44K = 2'h2;
   localparam logic [1:0] DEEMPH_48K = 2'h3;

   // one-pole smoothing weights, 256 = pass through
   localparam logic [8:0] DE_K_OFF = 9'h100;
   localparam logic [8:0] DE_K_32K = 9'h0C0;
   localparam logic [8:0] DE_K_44K = 9'h0B0;
   localparam logic [8:0] DE_K_48K = 9'h0A0;

   localparam int unsigned SAMPLE_W   = 24;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned HPF_SHIFT  = 10;
   localparam logic [8:0]  GAIN_FULL  = 9'h100;

   // decimation ratio log2 per sample rate select, index 0 in the low slot
   localparam logic [3:0][2:0] DEC_LOG2 = {3'h2, 3'h3, 3'h4, 3'h5};

endpackage

// ### design/sync_fifo.sv
`timescale 1ns/1ns
module sync_fifo #(
   parameter int unsigned W     = 48,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         inValid,
   input  wire logic [W-1:0] inData,
   output logic              inReady,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wrPtr;
      logic [AW-1:0]           rdPtr;
      logic [AW:0]             count;
      logic                    inReady;
      logic                    outValid;
      logic [W-1:0]            outData;
   } fifo_s;

   fifo_s q;
   fifo_s d;
   logic  push;
   logic  pop;

   always_comb begin
      d = q;
      push = inValid && q.inReady;
      pop = (q.count != '0) && (!q.outValid || outReady);
      if (outReady && q.outValid) begin
         d.outValid = 1'b0;
      end
      // output stage keeps the data path registered to the port
      if (pop) begin
         d.outData = q.mem[q.rdPtr];
         d.outValid = 1'b1;
         d.rdPtr = q.rdPtr + 1'b1;
      end
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = q.wrPtr + 1'b1;
      end
      d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
      d.inReady = d.count < (AW+1)'(DEPTH);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign inReady  = q.inReady;
   assign outValid = q.outValid;
   assign outData  = q.outData;
endmodule

// ### design/codec_path_control.sv
// What this block does
// - source select one picks microphone, zero line
// - both ADC channels share one source
// - highpass disable bit zero enables filter
// - enabled filter tracks and subtracts dc offset
// - disabled filter holds or clears offset
// - held offset frozen until filter reenabled or hold bit cleared
// - decimation at 24-bit to chosen rate
// - filter type follows sample rate automatically
// - interpolation at 24-bit to oversampled data
// - deemphasis select picks 48/44.1/32 or off
// - soft mute ramps DAC down, clear restores
// - DAC-only routing carries DAC alone
// - bypass bit sums line inputs into output
// - sidetone bit sums microphone into output
// - DAC select bit routes DAC to summer
// - mic bias off in standby
`timescale 1ns/1ns
module codec_path_control (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ctrlWrite,
   input  wire logic [6:0]  ctrlAddr,
   input  wire logic [8:0]  ctrlData,
   input  wire logic [6:0]  rdAddr,
   output logic [8:0]       rdData,
   input  wire logic        standby,
   input  wire logic [1:0]  sampleRateSel,
   input  wire logic        rawValid,
   input  wire logic [23:0] lineAdcLeft,
   input  wire logic [23:0] lineAdcRight,
   input  wire logic [23:0] micAdc,
   output logic             rawReady,
   output logic             adcOutValid,
   input  wire logic        adcOutReady,
   output logic [23:0]      adcOutLeft,
   output logic [23:0]      adcOutRight,
   input  wire logic        dacInValid,
   input  wire logic [23:0] dacInLeft,
   input  wire logic [23:0] dacInRight,
   output logic             dacInReady,
   input  wire logic        dacTick,
   output logic [23:0]      dacOutLeft,
   output logic [23:0]      dacOutRight,
   input  wire logic [23:0] lineInLeft,
   input  wire logic [23:0] lineInRight,
   input  wire logic [23:0] micIn,
   output logic [23:0]      leftLineOut,
   output logic [23:0]      rightLineOut,
   output logic             micBiasOutput
);
   localparam int unsigned SW = codec_path_pkg::SAMPLE_W;

   typedef struct packed {
      logic [8:0]           analog;
      logic [8:0]           digital;
      logic [8:0]           rdData;
      logic                 rawReady;
      logic [1:0][31:0]     acc;
      logic [4:0]           decCnt;
      logic [1:0][SW-1:0]   offset;
      logic                 pendValid;
      logic [1:0][SW-1:0]   pend;
      logic                 dacInReady;
      logic [1:0][SW-1:0]   target;
      logic [1:0][SW-1:0]   deemph;
      logic [8:0]           gain;
      logic [1:0][SW-1:0]   dacOut;
      logic [1:0][SW-1:0]   lineOut;
      logic                 mic_bias_output;
   } path_s;

   path_s               q;
   path_s               d;
   logic [1:0][SW-1:0]  src;
   logic [1:0][SW-1:0]  lineIn;
   logic [2:0]          decLog2;
   logic [4:0]          decLast;
   logic [8:0]          deK;
   logic                fifoReady;
   logic                input_source_select;
   logic                hpDisable;
   logic                holdOffset;

   function automatic logic [SW-1:0] sat(input logic signed [SW+1:0] v);
      logic signed [SW+1:0] hi;
      logic signed [SW+1:0] lo;
      hi = (SW+2)'({1'b0, {(SW-1){1'b1}}});
      lo = -hi - (SW+2)'(1);
      if (v > hi) begin
         sat = {1'b0, {(SW-1){1'b1}}};
      end else if (v < lo) begin
         sat = {1'b1, {(SW-1){1'b0}}};
      end else begin
         sat = v[SW-1:0];
      end
   endfunction

   assign input_source_select      = q.analog[codec_path_pkg::SRC_SEL_BIT];
   assign hpDisable  = q.digital[codec_path_pkg::HPD_BIT];
   assign holdOffset = q.digital[codec_path_pkg::HOLD_BIT];
   assign lineIn[0]  = lineInLeft;
   assign lineIn[1]  = lineInRight;
   // one shared switch feeds both channels
   assign src[0]     = input_source_select ? micAdc : lineAdcLeft;
   assign src[1]     = input_source_select ? micAdc : lineAdcRight;
   // decimation length tracks the rate, no separate filter setting
   assign decLog2    = codec_path_pkg::DEC_LOG2[sampleRateSel];
   assign decLast    = 5'((32'h1 << decLog2) - 32'h1);

   always_comb begin
      unique case (q.digital[codec_path_pkg::DEEMPH_LSB +: 2])
         codec_path_pkg::DEEMPH_32K: deK = codec_path_pkg::DE_K_32K;
         codec_path_pkg::DEEMPH_44K: deK = codec_path_pkg::DE_K_44K;
         codec_path_pkg::DEEMPH_48K: deK = codec_path_pkg::DE_K_48K;
         default:                    deK = codec_path_pkg::DE_K_OFF;
      endcase
   end

   always_comb begin
      logic signed [SW:0]   x;
      logic signed [SW:0]   diff;
      logic signed [SW+9:0] prod;
      logic signed [SW+1:0] sum;
      x = '0;
      diff = '0;
      prod = '0;
      sum = '0;
      d = q;

      // control writes land on the next edge and hold
      if (ctrlWrite && ctrlAddr == codec_path_pkg::REG_ANALOG) begin
         d.analog = ctrlData;
      end
      if (ctrlWrite && ctrlAddr == codec_path_pkg::REG_DIGITAL) begin
         d.digital = ctrlData;
      end
      unique case (rdAddr)
         codec_path_pkg::REG_ANALOG:  d.rdData = q.analog;
         codec_path_pkg::REG_DIGITAL: d.rdData = q.digital;
         default:                     d.rdData = '0;
      endcase

      // record path: decimate, then remove dc
      if (q.pendValid && fifoReady) begin
         d.pendValid = 1'b0;
      end
      if (!hpDisable) begin
         // nothing to do here, tracking happens per output sample
      end else if (!holdOffset) begin
         d.offset = '0;
      end
      if (rawValid && q.rawReady) begin
         for (int c = 0; c < 2; c++) begin
            d.acc[c] = q.acc[c] + {{8{src[c][SW-1]}}, src[c]};
         end
         d.decCnt = q.decCnt + 5'h1;
         if (q.decCnt >= decLast) begin
            d.decCnt = '0;
            d.pendValid = 1'b1;
            for (int c = 0; c < 2; c++) begin
               x = (SW+1)'($signed(d.acc[c]) >>> decLog2);
               diff = x - $signed({q.offset[c][SW-1], q.offset[c]});
               if (!hpDisable) begin
                  // output uses the running estimate, then it moves
                  d.pend[c] = sat((SW+2)'(diff));
                  d.offset[c] = SW'($signed(q.offset[c])
                              + (diff >>> codec_path_pkg::HPF_SHIFT));
               end else if (holdOffset) begin
                  d.pend[c] = sat((SW+2)'(diff));
               end else begin
                  d.pend[c] = x[SW-1:0];
               end
               d.acc[c] = '0;
            end
         end
      end
      // a pending sample stalls the raw stream until the fifo takes it
      d.rawReady = !d.pendValid;

      // playback path: hold input, smooth per tick, ramp gain
      d.dacInReady = 1'b1;
      if (dacInValid && q.dacInReady) begin
         d.target[0] = dacInLeft;
         d.target[1] = dacInRight;
      end
      if (dacTick) begin
         for (int c = 0; c < 2; c++) begin
            diff = $signed({q.target[c][SW-1], q.target[c]})
                 - $signed({q.deemph[c][SW-1], q.deemph[c]});
            prod = (SW+10)'(diff * $signed({1'b0, deK})) >>> 8;
            d.deemph[c] = SW'($signed(q.deemph[c]) + prod);
            prod = (SW+10)'($signed(q.deemph[c]) * $signed({1'b0, q.gain})) >>> 8;
            d.dacOut[c] = prod[SW-1:0];
         end
         // one step per tick avoids an audible click
         if (q.digital[codec_path_pkg::MUTE_BIT]) begin
            if (q.gain != '0) begin
               d.gain = q.gain - 9'h001;
            end
         end else if (q.gain != codec_path_pkg::GAIN_FULL) begin
            d.gain = q.gain + 9'h001;
         end
      end

      // line output summer; clipping matches a rail-limited output
      for (int c = 0; c < 2; c++) begin
         sum = '0;
         if (q.analog[codec_path_pkg::DAC_SEL_BIT]) begin
            sum = sum + $signed({{2{q.dacOut[c][SW-1]}}, q.dacOut[c]});
         end
         if (q.analog[codec_path_pkg::BYPASS_BIT]) begin
            sum = sum + $signed({{2{lineIn[c][SW-1]}}, lineIn[c]});
         end
         if (q.analog[codec_path_pkg::SIDETONE_BIT]) begin
            sum = sum + $signed({{2{micIn[SW-1]}}, micIn});
         end
         d.lineOut[c] = sat(sum);
      end

      d.mic_bias_output = !standby;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
         q.analog <= codec_path_pkg::ANALOG_RST;
         q.digital <= codec_path_pkg::DIGITAL_RST;
      end else begin
         q <= d;
      end
   end

   sync_fifo #(
      .W     (2 * SW),
      .DEPTH (codec_path_pkg::FIFO_DEPTH)
   ) i_sync_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .inValid  (q.pendValid),
      .inData   ({q.pend[1], q.pend[0]}),
      .inReady  (fifoReady),
      .outValid (adcOutValid),
      .outReady (adcOutReady),
      .outData  ({adcOutRight, adcOutLeft})
   );

   assign rdData        = q.rdData;
   assign rawReady      = q.rawReady;
   assign dacInReady    = q.dacInReady;
   assign dacOutLeft    = q.dacOut[0];
   assign dacOutRight   = q.dacOut[1];
   assign leftLineOut   = q.lineOut[0];
   assign rightLineOut  = q.lineOut[1];
   assign micBiasOutput = q.mic_bias_output;

   sequence s_analogWrite;
      ctrlWrite && ctrlAddr == codec_path_pkg::REG_ANALOG;
   endsequence
   sequence s_digitalWrite;
      ctrlWrite && ctrlAddr == codec_path_pkg::REG_DIGITAL;
   endsequence

   property p_analogWrite;
      @(posedge sys_clk) disable iff (rst)
      s_analogWrite |=> q.analog == $past(ctrlData);
   endproperty
   a_analogWrite: assert property (p_analogWrite) else $error("analog write lost");

   property p_digitalWrite;
      @(posedge sys_clk) disable iff (rst)
      s_digitalWrite |=> q.digital == $past(ctrlData);
   endproperty
   a_digitalWrite: assert property (p_digitalWrite) else $error("digital write lost");

   property p_sharedSource;
      @(posedge sys_clk) disable iff (rst)
      input_source_select |-> src[0] == micAdc && src[1] == micAdc;
   endproperty
   a_sharedSource: assert property (p_sharedSource) else $error("source not mic");

   property p_offsetFrozen;
      @(posedge sys_clk) disable iff (rst)
      hpDisable && holdOffset |=> $stable(q.offset);
   endproperty
   a_offsetFrozen: assert property (p_offsetFrozen) else $error("held offset moved");

   property p_offsetCleared;
      @(posedge sys_clk) disable iff (rst)
      hpDisable && !holdOffset ##1 hpDisable && !holdOffset |-> q.offset == '0;
   endproperty
   a_offsetCleared: assert property (p_offsetCleared) else $error("offset not cleared");

   property p_muteRamp;
      @(posedge sys_clk) disable iff (rst)
      dacTick && q.digital[codec_path_pkg::MUTE_BIT] && q.gain != '0
         |=> q.gain == $past(q.gain) - 9'h001;
   endproperty
   a_muteRamp: assert property (p_muteRamp) else $error("mute ramp wrong");

   property p_unmuteRamp;
      @(posedge sys_clk) disable iff (rst)
      dacTick && !q.digital[codec_path_pkg::MUTE_BIT] && q.gain < codec_path_pkg::GAIN_FULL
         |=> q.gain == $past(q.gain) + 9'h001;
   endproperty
   a_unmuteRamp: assert property (p_unmuteRamp) else $error("unmute ramp wrong");

   property p_dacOnly;
      @(posedge sys_clk) disable iff (rst)
      q.analog[5:3] == 3'h2 |=> leftLineOut == $past(q.dacOut[0]);
   endproperty
   a_dacOnly: assert property (p_dacOnly) else $error("dac only mixed");

   property p_deemphOff;
      @(posedge sys_clk) disable iff (rst)
      dacTick && deK == codec_path_pkg::DE_K_OFF |=> q.deemph == $past(q.target);
   endproperty
   a_deemphOff: assert property (p_deemphOff) else $error("deemphasis not bypassed");

   property p_biasStandby;
      @(posedge sys_clk) disable iff (rst)
      standby [*2] |-> !micBiasOutput;
   endproperty
   a_biasStandby: assert property (p_biasStandby) else $error("bias on in standby");
endmodule

// ### tb/host_model.sv
`timescale 1ns/1ns
module host_model (
   input  wire logic       sys_clk,
   output logic            ctrlWrite,
   output logic [6:0]      ctrlAddr,
   output logic [8:0]      ctrlData,
   output logic [6:0]      rdAddr,
   input  wire logic [8:0] rdData
);
   initial begin
      ctrlWrite = 1'b0;
      ctrlAddr  = 7'h00;
      ctrlData  = 9'h000;
      rdAddr    = 7'h00;
   end

   // one word per pulse; data inverted after release so stale values show
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(posedge sys_clk);
      ctrlWrite <= 1'b1;
      ctrlAddr  <= a;
      ctrlData  <= d;
      @(posedge sys_clk);
      ctrlWrite <= 1'b0;
      ctrlData  <= ~d;
   endtask

   task automatic rd(input logic [6:0] a, output logic [8:0] d);
      @(posedge sys_clk);
      rdAddr <= a;
      repeat (2) @(posedge sys_clk);
      #1 d = rdData;
   endtask

   // soft mute plus both analog paths cleared
   task automatic silence();
      wr(codec_path_pkg::REG_DIGITAL, 9'h008);
      wr(codec_path_pkg::REG_ANALOG, 9'h000);
   endtask
endmodule

// ### tb/codec_path_control_tb.sv
`timescale 1ns/1ns
module codec_path_control_tb;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ctrlWrite, standby, rawValid, adcOutReady, rawReady, adcOutValid;
   logic        dacInValid, dacTick, micBiasOutput, dacInReady;
   logic [6:0]  ctrlAddr, rdAddr;
   logic [8:0]  ctrlData, rdData, rv;
   logic [1:0]  sampleRateSel;
   logic [23:0] lineAdcLeft, lineAdcRight, micAdc, adcOutLeft, adcOutRight;
   logic [23:0] dacInLeft, dacInRight, dacOutLeft, dacOutRight;
   logic [23:0] lineInLeft, lineInRight, micIn, leftLineOut, rightLineOut, gotL, gotR, a;
   logic [8:0]  kTab [4];
   int          num_errors = 0;
   int          checks = 0;
   int          cnt;

   always #5 sys_clk = ~sys_clk;

   initial begin
      standby = 0; sampleRateSel = 0; rawValid = 0; adcOutReady = 1;
      lineAdcLeft = 0; lineAdcRight = 0; micAdc = 0; dacInValid = 1; dacTick = 0;
      dacInLeft = 0; dacInRight = 0; lineInLeft = 0; lineInRight = 0; micIn = 0;
      kTab = '{codec_path_pkg::DE_K_OFF, codec_path_pkg::DE_K_32K,
               codec_path_pkg::DE_K_44K, codec_path_pkg::DE_K_48K};
   end

   host_model i_host_model (.sys_clk, .ctrlWrite, .ctrlAddr, .ctrlData, .rdAddr, .rdData);

   codec_path_control i_codec_path_control (.sys_clk, .rst, .ctrlWrite, .ctrlAddr,
      .ctrlData, .rdAddr, .rdData, .standby, .sampleRateSel, .rawValid, .lineAdcLeft,
      .lineAdcRight, .micAdc, .rawReady, .adcOutValid, .adcOutReady, .adcOutLeft,
      .adcOutRight, .dacInValid, .dacInLeft, .dacInRight, .dacInReady, .dacTick,
      .dacOutLeft, .dacOutRight, .lineInLeft, .lineInRight, .micIn, .leftLineOut,
      .rightLineOut, .micBiasOutput);

   task automatic check(input string n, input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk) dacTick <= 1'b1;
         @(posedge sys_clk) dacTick <= 1'b0;
      end
   endtask

   // sink always ready, so a valid seen at negedge transfers at the next edge
   task automatic getWords(input int n);
      repeat (n) begin
         do @(negedge sys_clk); while (adcOutValid !== 1'b1);
         gotL = adcOutLeft;
         gotR = adcOutRight;
         @(posedge sys_clk);
      end
   endtask

   task automatic t_reset();
      i_host_model.rd(7'h04, rv);
      check("analogRst", 24'(rv), 24'(codec_path_pkg::ANALOG_RST));
      i_host_model.rd(7'h05, rv);
      check("digitalRst", 24'(rv), 24'(codec_path_pkg::DIGITAL_RST));
      check("biasOn", 24'(micBiasOutput), 24'h000001);
      check("dacReady", 24'(dacInReady), 24'h000001);
      @(posedge sys_clk) standby <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check("biasStandby", 24'(micBiasOutput), 24'h000000);
      standby <= 1'b0;
      i_host_model.wr(7'h04, 9'h155);
      i_host_model.wr(7'h07, 9'h0FF);
      i_host_model.rd(7'h04, rv);
      check("regHold", 24'(rv), 24'h000155);
      i_host_model.rd(7'h07, rv);
      check("unmapped", 24'(rv), 24'h000000);
      $display("test reset done");
   endtask

   task automatic t_route();
      logic [8:0]  sel [4] = '{9'h000, 9'h008, 9'h020, 9'h028};
      logic [23:0] exp [4] = '{24'h0, 24'h000100, 24'h000040, 24'h000140};
      lineInLeft <= 24'h000100;
      lineInRight <= 24'h000200;
      micIn <= 24'h000040;
      for (int i = 0; i < 4; i++) begin
         i_host_model.wr(7'h04, sel[i]);
         repeat (3) @(posedge sys_clk);
         check("routeL", leftLineOut, exp[i]);
      end
      check("routeR", rightLineOut, 24'h000240);
      $display("test route done");
   endtask

   task automatic t_deemph(input logic [1:0] c, input logic [8:0] k);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      dacInLeft <= 24'h0;
      dacInRight <= 24'h0;
      i_host_model.wr(7'h05, {6'h00, c, 1'b0});
      ticks(260);
      dacInLeft <= 24'h010000;
      dacInRight <= 24'h008000;
      ticks(2);
      // output is launched by the last tick edge, look once it has settled
      @(negedge sys_clk);
      check("deemphL", dacOutLeft, 24'(k) << 8);
      check("deemphR", dacOutRight, 24'(k) << 7);
      $display("test deemphasis done");
   endtask

   task automatic t_mute();
      i_host_model.wr(7'h05, 9'h008);
      ticks(10);
      check("rampMid", 24'(dacOutLeft > 0 && dacOutLeft < 24'h010000), 24'h1);
      ticks(300);
      check("muted", dacOutLeft, 24'h0);
      i_host_model.wr(7'h05, 9'h000);
      ticks(300);
      check("restored", dacOutLeft, 24'h010000);
      lineInLeft <= 24'h000100;
      micIn <= 24'h000040;
      i_host_model.wr(7'h04, 9'h010);
      repeat (3) @(posedge sys_clk);
      check("dacOnly", leftLineOut, 24'h010000);
      i_host_model.wr(7'h04, 9'h000);
      repeat (3) @(posedge sys_clk);
      check("dacOff", leftLineOut, 24'h0);
      i_host_model.wr(7'h04, 9'h038);
      i_host_model.silence();
      ticks(300);
      @(negedge sys_clk);
      check("silentDac", dacOutLeft, 24'h0);
      check("silentL", leftLineOut, 24'h0);
      check("silentR", rightLineOut, 24'h0);
      $display("test mute done");
   endtask

   // steady stream: one word per ratio samples plus one stall cycle
   task automatic t_rate();
      int n;
      rawValid <= 1'b1;
      for (int s = 3; s >= 0; s--) begin
         @(posedge sys_clk) sampleRateSel <= 2'(s);
         getWords(2);
         n = 0;
         do begin
            @(negedge sys_clk);
            n++;
         end while (adcOutValid !== 1'b1);
         check("decRatio", 24'(n), 24'((1 << codec_path_pkg::DEC_LOG2[s]) + 1));
      end
      $display("test rate done");
   endtask

   task automatic t_adc();
      lineAdcLeft <= 24'h001000;
      lineAdcRight <= 24'h002000;
      micAdc <= 24'h003000;
      rawValid <= 1'b1;
      i_host_model.wr(7'h05, 9'h001);
      getWords(8);
      check("lineL", gotL, 24'h001000);
      check("lineR", gotR, 24'h002000);
      i_host_model.wr(7'h04, 9'h004);
      getWords(8);
      check("micL", gotL, 24'h003000);
      check("micR", gotR, 24'h003000);
      i_host_model.wr(7'h05, 9'h010);
      getWords(40);
      check("hpfTracks", 24'(gotL < 24'h003000), 24'h1);
      i_host_model.wr(7'h05, 9'h011);
      getWords(8);
      a = 24'h003000 - gotL;
      check("heldNonZero", 24'(a != 0), 24'h1);
      micAdc <= 24'h005000;
      getWords(8);
      check("heldFrozen", 24'h005000 - gotL, a);
      i_host_model.wr(7'h05, 9'h001);
      getWords(8);
      check("offsetClear", gotL, 24'h005000);
      adcOutReady <= 1'b0;
      // output stage, sixteen slots and the pending word must all fill
      cnt = (codec_path_pkg::FIFO_DEPTH + 2) * ((1 << codec_path_pkg::DEC_LOG2[0]) + 1);
      repeat (cnt + 20) @(posedge sys_clk);
      check("fifoFull", 24'(rawReady), 24'h0);
      rawValid <= 1'b0;
      adcOutReady <= 1'b1;
      cnt = 0;
      repeat (60) @(negedge sys_clk) if (adcOutValid === 1'b1) cnt++;
      check("drained", 24'(cnt >= 16), 24'h1);
      check("empty", 24'(adcOutValid), 24'h0);
      $display("test adc done");
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_route();
      t_rate();
      t_adc();
      for (int c = 3; c >= 0; c--) t_deemph(c[1:0], kTab[c]);
      t_mute();
      complete_run();
   end

   // roughly seven times the expected run length
   initial begin
      #500000;
      num_errors++;
      complete_run();
   end
endmodule
